// *** ptv_pkg.sv ***
// package for the sample output register set: map, field layout, types
// assumes one clock domain; the serial front end and the converter share it
// Summary of operation
// - pressure is 20-bit unsigned, two fraction bits
// - integer in high, mid, low[7:6]; fraction low[5:4]
// - 01h-03h give pressure bits, reset zero
// - pressure meaning follows height mode select
// - status through temperature burst readable 00h-05h
// - temperature is signed 12-bit, four fraction bits
// - 04h integer degrees, 05h fraction upper nibble
// - 07h-09h hold newest minus previous pressure
// - pressure change uses the pressure byte layout
// - pressure change updates in every fifo mode
// - fifo off: bytes show latest sample live; a burst reads the copy frozen when it starts
// - fifo off: high pressure read clears pressure flags
// - fifo off: high temperature read clears temperature flags
// - fifo on: fifo data read clears flags
package ptv_pkg;

    localparam int P_W     = 20;
    localparam int T_W     = 12;
    localparam int BYTE_W  = 8;
    localparam int NIB_W   = 4;

    // byte slices of the sample words
    localparam int P_HI_LSB  = 12;
    localparam int P_MID_LSB = 4;
    localparam int T_HI_LSB  = 4;

    localparam logic [7:0] ADDR_STATUS    = 8'h00;
    localparam logic [7:0] ADDR_P_HIGH    = 8'h01;
    localparam logic [7:0] ADDR_P_MID     = 8'h02;
    localparam logic [7:0] ADDR_P_LOW     = 8'h03;
    localparam logic [7:0] ADDR_T_HIGH    = 8'h04;
    localparam logic [7:0] ADDR_T_LOW     = 8'h05;
    localparam logic [7:0] ADDR_STATUS_B  = 8'h06;
    localparam logic [7:0] ADDR_D_HIGH    = 8'h07;
    localparam logic [7:0] ADDR_D_MID     = 8'h08;
    localparam logic [7:0] ADDR_D_LOW     = 8'h09;

    localparam logic [7:0] ADDR_STEP      = 8'h01;
    localparam logic [3:0] RSV_NIB        = 4'h0;
    localparam logic [7:0] UNMAPPED_BYTE  = 8'h00;
    localparam logic [1:0] FIFO_OFF       = 2'h0;

    // status byte bit positions
    localparam int BIT_PTOW = 7;
    localparam int BIT_POW  = 6;
    localparam int BIT_TOW  = 5;
    localparam int BIT_PTDR = 3;
    localparam int BIT_PDR  = 2;
    localparam int BIT_TDR  = 1;

    typedef struct packed {
        logic [P_W-1:0] p;
        logic [T_W-1:0] t;
        logic [P_W-1:0] d;
    } ptv_sample_type;

    localparam ptv_sample_type SAMPLE_RESET = '0;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_BURST = 2'b10
    } ptv_state_type;

endpackage : ptv_pkg

// *** ptv_snap.sv ***
// snapshot register: follows the live sample set, freezes while held
// assumes hold_i comes from logic on clk_sys_i
`timescale 1ns/1ps
module ptv_snap (
    // clock and reset
    input  wire logic                    clk_sys_i,
    input  wire logic                    nrst_i,
    // control
    input  wire logic                    hold_i,
    // data
    input  wire ptv_pkg::ptv_sample_type live_i,
    output ptv_pkg::ptv_sample_type      snap_o
);
    ptv_pkg::ptv_sample_type snap_q;
    ptv_pkg::ptv_sample_type snap_d;

    always_comb begin
        snap_d = hold_i ? snap_q : live_i;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            snap_q <= ptv_pkg::SAMPLE_RESET;
        end else begin
            snap_q <= snap_d;
        end
    end

    assign snap_o = snap_q;

endmodule : ptv_snap

// *** ptv_out_regs.sv ***
// sample output registers with auto-incrementing byte read port
// assumes a serial slave front end on clk_sys_i: it pulses start_i with
// the register address, rd_stb_i once per byte, stop_i at the end
`timescale 1ns/1ps
module ptv_out_regs (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    // converter side
    input  wire logic [19:0] pressure_value_i,
    input  wire logic        pressure_valid_i,
    input  wire logic [11:0] temperature_value_i,
    input  wire logic        temperature_valid_i,
    input  wire logic        height_mode_select_i,
    input  wire logic [1:0]  fifo_mode_i,
    input  wire logic        fifo_data_rd_i,
    // register read port
    input  wire logic        start_i,
    input  wire logic [7:0]  start_addr_i,
    input  wire logic        rd_stb_i,
    input  wire logic        stop_i,
    output logic      [7:0]  rd_data_o,
    output logic             rd_valid_o,
    // flags
    output logic             pressure_ready_flag_o,
    output logic             pressure_overrun_flag_o,
    output logic             temperature_ready_flag_o,
    output logic             temperature_overrun_flag_o,
    output logic             any_ready_flag_o,
    output logic             any_overrun_flag_o,
    output logic             height_mode_o
);

    // byte decode shared by the read path
    function automatic logic [7:0] read_byte(
        input logic [7:0]              a,
        input ptv_pkg::ptv_sample_type s,
        input logic [7:0]              st
    );
        logic [7:0] r;
        r = ptv_pkg::UNMAPPED_BYTE;
        if (a == ptv_pkg::ADDR_STATUS || a == ptv_pkg::ADDR_STATUS_B) begin
            r = st;
        end else if (a == ptv_pkg::ADDR_P_HIGH) begin
            r = s.p[ptv_pkg::P_HI_LSB +: ptv_pkg::BYTE_W];
        end else if (a == ptv_pkg::ADDR_P_MID) begin
            r = s.p[ptv_pkg::P_MID_LSB +: ptv_pkg::BYTE_W];
        end else if (a == ptv_pkg::ADDR_P_LOW) begin
            r = {s.p[0 +: ptv_pkg::NIB_W], ptv_pkg::RSV_NIB};
        end else if (a == ptv_pkg::ADDR_T_HIGH) begin
            r = s.t[ptv_pkg::T_HI_LSB +: ptv_pkg::BYTE_W];
        end else if (a == ptv_pkg::ADDR_T_LOW) begin
            r = {s.t[0 +: ptv_pkg::NIB_W], ptv_pkg::RSV_NIB};
        end else if (a == ptv_pkg::ADDR_D_HIGH) begin
            r = s.d[ptv_pkg::P_HI_LSB +: ptv_pkg::BYTE_W];
        end else if (a == ptv_pkg::ADDR_D_MID) begin
            r = s.d[ptv_pkg::P_MID_LSB +: ptv_pkg::BYTE_W];
        end else if (a == ptv_pkg::ADDR_D_LOW) begin
            r = {s.d[0 +: ptv_pkg::NIB_W], ptv_pkg::RSV_NIB};
        end
        return r;
    endfunction : read_byte

    // live sample set
    ptv_pkg::ptv_sample_type live_q;
    ptv_pkg::ptv_sample_type live_d;
    logic                    hmode_q;
    logic                    hmode_d;

    always_comb begin
        live_d  = live_q;
        hmode_d = hmode_q;
        if (pressure_valid_i) begin
            // stored as delivered: pascals in barometer mode, else height
            live_d.p = pressure_value_i;
            hmode_d  = height_mode_select_i;
            // wraps modulo 2^20, same layout as the sample
            live_d.d = pressure_value_i - live_q.p;
        end
        if (temperature_valid_i) begin
            live_d.t = temperature_value_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            live_q  <= ptv_pkg::SAMPLE_RESET;
            hmode_q <= 1'b0;
        end else begin
            live_q  <= live_d;
            hmode_q <= hmode_d;
        end
    end

    // burst sequencer and address pointer
    ptv_pkg::ptv_state_type state_q;
    ptv_pkg::ptv_state_type state_d;
    logic [7:0]             ptr_q;
    logic [7:0]             ptr_d;
    logic                   rd_go;

    assign rd_go = rd_stb_i && (state_q == ptv_pkg::ST_BURST);

    always_comb begin
        state_d = state_q;
        ptr_d   = ptr_q;
        case (state_q)
            ptv_pkg::ST_IDLE: begin
                if (start_i) begin
                    state_d = ptv_pkg::ST_BURST;
                    ptr_d   = start_addr_i;
                end
            end
            ptv_pkg::ST_BURST: begin
                if (stop_i) begin
                    state_d = ptv_pkg::ST_IDLE;
                end else if (start_i) begin
                    ptr_d = start_addr_i;
                end else if (rd_stb_i) begin
                    ptr_d = ptr_q + ptv_pkg::ADDR_STEP;
                end
            end
            default: begin
                state_d = ptv_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= ptv_pkg::ST_IDLE;
            ptr_q   <= ptv_pkg::ADDR_STATUS;
        end else begin
            state_q <= state_d;
            ptr_q   <= ptr_d;
        end
    end

    // frozen copy so a sample landing mid-burst cannot tear the read
    ptv_pkg::ptv_sample_type snap;

    ptv_snap u_snap (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .hold_i    (state_q == ptv_pkg::ST_BURST),
        .live_i    (live_q),
        .snap_o    (snap)
    );

    // ready and overrun flags; a new sample beats a same-cycle clear
    logic pdr_q, pow_q, tdr_q, tow_q, ptdr_q, ptow_q;
    logic pdr_d, pow_d, tdr_d, tow_d, ptdr_d, ptow_d;
    logic fifo_off, p_clr, t_clr, p_ovr, t_ovr;
    logic [7:0] status;

    always_comb begin
        fifo_off = (fifo_mode_i == ptv_pkg::FIFO_OFF);
        p_clr    = (fifo_off && rd_go && ptr_q == ptv_pkg::ADDR_P_HIGH)
                 || (!fifo_off && fifo_data_rd_i);
        t_clr    = (fifo_off && rd_go && ptr_q == ptv_pkg::ADDR_T_HIGH)
                 || (!fifo_off && fifo_data_rd_i);
        p_ovr    = pressure_valid_i && pdr_q;
        t_ovr    = temperature_valid_i && tdr_q;
        pdr_d    = pressure_valid_i || (pdr_q && !p_clr);
        pow_d    = p_ovr || (pow_q && !p_clr);
        tdr_d    = temperature_valid_i || (tdr_q && !t_clr);
        tow_d    = t_ovr || (tow_q && !t_clr);
        ptdr_d   = pressure_valid_i || temperature_valid_i
                 || (ptdr_q && !(p_clr || t_clr));
        ptow_d   = p_ovr || t_ovr || (ptow_q && !(p_clr || t_clr));
        status   = ptv_pkg::UNMAPPED_BYTE;
        status[ptv_pkg::BIT_PTOW] = ptow_q;
        status[ptv_pkg::BIT_POW]  = pow_q;
        status[ptv_pkg::BIT_TOW]  = tow_q;
        status[ptv_pkg::BIT_PTDR] = ptdr_q;
        status[ptv_pkg::BIT_PDR]  = pdr_q;
        status[ptv_pkg::BIT_TDR]  = tdr_q;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pdr_q  <= 1'b0;
            pow_q  <= 1'b0;
            tdr_q  <= 1'b0;
            tow_q  <= 1'b0;
            ptdr_q <= 1'b0;
            ptow_q <= 1'b0;
        end else begin
            pdr_q  <= pdr_d;
            pow_q  <= pow_d;
            tdr_q  <= tdr_d;
            tow_q  <= tow_d;
            ptdr_q <= ptdr_d;
            ptow_q <= ptow_d;
        end
    end

    // read data register
    logic [7:0] rd_data_q, rd_data_d;
    logic       rd_valid_q, rd_valid_d;

    always_comb begin
        rd_valid_d = rd_go;
        rd_data_d  = rd_go ? read_byte(ptr_q, snap, status) : rd_data_q;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_data_q  <= ptv_pkg::UNMAPPED_BYTE;
            rd_valid_q <= 1'b0;
        end else begin
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    assign rd_data_o                  = rd_data_q;
    assign rd_valid_o                 = rd_valid_q;
    assign pressure_ready_flag_o      = pdr_q;
    assign pressure_overrun_flag_o    = pow_q;
    assign temperature_ready_flag_o   = tdr_q;
    assign temperature_overrun_flag_o = tow_q;
    assign any_ready_flag_o           = ptdr_q;
    assign any_overrun_flag_o         = ptow_q;
    assign height_mode_o              = hmode_q;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    property p_burst_answer;
        rd_go |=> rd_valid_o ##1 (!rd_valid_o || $past(rd_go));
    endproperty
    a_burst_answer: assert property (p_burst_answer)
        else $error("burst read gave no single-cycle answer");

    property p_ptr_step;
        rd_go && !start_i && !stop_i |=> ptr_q == $past(ptr_q) + 8'h01;
    endproperty
    a_ptr_step: assert property (p_ptr_step)
        else $error("address did not auto-increment");

    property p_p_high;
        rd_go && ptr_q == ptv_pkg::ADDR_P_HIGH
            |=> rd_data_o == $past(snap.p[19:12]);
    endproperty
    a_p_high: assert property (p_p_high)
        else $error("pressure high byte wrong");

    property p_low_rsv;
        rd_go && (ptr_q == ptv_pkg::ADDR_P_LOW || ptr_q == ptv_pkg::ADDR_T_LOW
                  || ptr_q == ptv_pkg::ADDR_D_LOW)
            |=> rd_data_o[3:0] == 4'h0;
    endproperty
    a_low_rsv: assert property (p_low_rsv)
        else $error("reserved nibble not zero");

    property p_t_low;
        rd_go && ptr_q == ptv_pkg::ADDR_T_LOW
            |=> rd_data_o[7:4] == $past(snap.t[3:0]);
    endproperty
    a_t_low: assert property (p_t_low)
        else $error("temperature fraction wrong");

    property p_delta;
        pressure_valid_i
            |=> live_q.d == 20'($past(pressure_value_i) - $past(live_q.p));
    endproperty
    a_delta: assert property (p_delta)
        else $error("pressure change not updated");

    property p_pclear;
        fifo_off && rd_go && ptr_q == ptv_pkg::ADDR_P_HIGH
            && !pressure_valid_i |=> !pdr_q && !pow_q;
    endproperty
    a_pclear: assert property (p_pclear)
        else $error("pressure flags not cleared by high byte read");

    property p_tclear;
        fifo_off && rd_go && ptr_q == ptv_pkg::ADDR_T_HIGH
            && !temperature_valid_i |=> !tdr_q && !tow_q;
    endproperty
    a_tclear: assert property (p_tclear)
        else $error("temperature flags not cleared by high byte read");

    property p_fclear;
        !fifo_off && fifo_data_rd_i && !pressure_valid_i
            && !temperature_valid_i |=> !pdr_q && !tdr_q;
    endproperty
    a_fclear: assert property (p_fclear)
        else $error("fifo data read did not clear flags");

    property p_set_wins;
        pressure_valid_i |=> pdr_q;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("new pressure sample lost its ready flag");

    property p_coherent;
        state_q == ptv_pkg::ST_BURST ##1 state_q == ptv_pkg::ST_BURST
            |-> $stable(snap);
    endproperty
    a_coherent: assert property (p_coherent)
        else $error("snapshot changed inside a burst");

endmodule : ptv_out_regs

// *** ptv_host_model.sv ***
// host side model of the register read port: start, byte strobes, stop
// assumes each strobe is answered by rd_valid_i one cycle later
`timescale 1ns/1ps
module ptv_host_model (
    // clock
    input  wire logic       clk_sys_i,
    // read port
    output logic            start_o,
    output logic      [7:0] start_addr_o,
    output logic            rd_stb_o,
    output logic            stop_o,
    input  wire logic [7:0] rd_data_i,
    input  wire logic       rd_valid_i
);
    logic [7:0] got [0:15];
    int         cnt = 0;
    initial begin
        start_o = 1'b0;
        start_addr_o = 8'h00;
        rd_stb_o = 1'b0;
        stop_o = 1'b0;
    end
    // answers stand one cycle, so the falling edge always sees them
    always @(negedge clk_sys_i) begin
        if (rd_valid_i === 1'b1 && cnt < 16) begin
            got[cnt] = rd_data_i;
            cnt++;
        end
    end
    // one transfer of n bytes from addr; gap idle cycles between strobes
    task burst(input logic [7:0] addr, input int n, input int gap);
        cnt = 0;
        @(posedge clk_sys_i);
        #1;
        start_o = 1'b1;
        start_addr_o = addr;
        @(posedge clk_sys_i);
        #1;
        start_o = 1'b0;
        // released address no longer shows the last value
        start_addr_o = ~addr;
        for (int i = 0; i < n; i++) begin
            rd_stb_o = 1'b1;
            @(posedge clk_sys_i);
            #1;
            if (gap > 0) begin
                rd_stb_o = 1'b0;
                repeat (gap) @(posedge clk_sys_i);
                #1;
            end
        end
        rd_stb_o = 1'b0;
        stop_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        stop_o = 1'b0;
        @(posedge clk_sys_i);
        #1;
    endtask : burst
endmodule : ptv_host_model

// *** ptv_out_regs_tb.sv ***
// self-checking bench for the sample output register set
// assumes the host model drives the read port; bench drives the converter
`timescale 1ns/1ps
module ptv_out_regs_tb;
    typedef struct {
        logic [19:0] p;
        logic [11:0] t;
        logic        hm;
        logic [7:0]  s0;
    } ptv_row_type;
    ptv_row_type rows [4] = '{
        '{20'h12345, 12'h19a, 1'b0, 8'h0e},
        '{20'hfffff, 12'h800, 1'b1, 8'h0e},
        '{20'h00001, 12'h7ff, 1'b0, 8'h0e},
        '{20'h00000, 12'hfff, 1'b1, 8'h0e}};
    logic        clk_sys_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [19:0] pv = '0;
    logic        pvld = 1'b0;
    logic [11:0] tv = '0;
    logic        tvld = 1'b0;
    logic        hm = 1'b0;
    logic [1:0]  fm = 2'h0;
    logic        frd = 1'b0;
    logic        st, stb, sp, vld, hmo;
    logic [7:0]  sa, rd;
    logic [5:0]  flags;
    logic [19:0] prev, dlt, op, od;
    logic [11:0] ot;
    int          error_cnt = 0;
    int          checks = 0;

    always #50 clk_sys_i = ~clk_sys_i;

    ptv_host_model host (.clk_sys_i(clk_sys_i), .start_o(st),
        .start_addr_o(sa), .rd_stb_o(stb), .stop_o(sp),
        .rd_data_i(rd), .rd_valid_i(vld));
    ptv_out_regs DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .pressure_value_i(pv), .pressure_valid_i(pvld),
        .temperature_value_i(tv), .temperature_valid_i(tvld),
        .height_mode_select_i(hm), .fifo_mode_i(fm), .fifo_data_rd_i(frd),
        .start_i(st), .start_addr_i(sa), .rd_stb_i(stb), .stop_i(sp),
        .rd_data_o(rd), .rd_valid_o(vld),
        .pressure_ready_flag_o(flags[5]),
        .pressure_overrun_flag_o(flags[4]),
        .temperature_ready_flag_o(flags[3]),
        .temperature_overrun_flag_o(flags[2]),
        .any_ready_flag_o(flags[1]), .any_overrun_flag_o(flags[0]),
        .height_mode_o(hmo));

    task chk(input logic [19:0] seen, input logic [19:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [7:0] eb(input int a, input logic [19:0] p,
        input logic [11:0] t, input logic [19:0] d, input logic [7:0] s);
        case (a)
            0, 6: eb = s;
            1: eb = p[19:12];
            2: eb = p[11:4];
            3: eb = {p[3:0], 4'h0};
            4: eb = t[11:4];
            5: eb = {t[3:0], 4'h0};
            7: eb = d[19:12];
            8: eb = d[11:4];
            9: eb = {d[3:0], 4'h0};
            default: eb = 8'h00;
        endcase
    endfunction : eb

    // compares an 11-byte burst from 00h; status bytes only if sc is set
    task chk_got(input logic [19:0] p, input logic [11:0] t,
        input logic [19:0] d, input logic [7:0] s0, input logic [7:0] s6,
        input bit sc);
        chk(20'(host.cnt), 20'd11);
        for (int a = 0; a < 11; a++) begin
            if (sc || (a != 0 && a != 6))
                chk(20'(host.got[a]), 20'(eb(a, p, t, d, a == 6 ? s6 : s0)));
        end
    endtask : chk_got

    task put(input logic [19:0] p, input logic [11:0] t, input logic h);
        @(posedge clk_sys_i);
        #1;
        pv = p;
        tv = t;
        hm = h;
        pvld = 1'b1;
        tvld = 1'b1;
        @(posedge clk_sys_i);
        #1;
        pvld = 1'b0;
        tvld = 1'b0;
        dlt = p - prev;
        prev = p;
    endtask : put

    task rst_chk;
        nrst_i = 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        nrst_i = 1'b1;
        prev = '0;
        host.burst(8'h00, 11, 0);
        chk_got('0, '0, '0, 8'h00, 8'h00, 1'b1);
        chk(20'(flags), 20'h0);
    endtask : rst_chk

    task results;
        if (error_cnt == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    initial begin
        repeat (4000) @(posedge clk_sys_i);
        error_cnt++;
        results();
    end

    initial begin
        rst_chk();
        foreach (rows[i]) begin
            put(rows[i].p, rows[i].t, rows[i].hm);
            chk(20'(hmo), 20'(rows[i].hm));
            host.burst(8'h00, 11, 0);
            chk_got(pv, tv, dlt, rows[i].s0, 8'h00, 1'b1);
            chk(20'(flags), 20'h0);
        end
        put(20'h2a5c3, 12'h0f1, 1'b0);
        put(20'h2a5d7, 12'h0f2, 1'b0);
        chk(20'(flags), 20'h3f);
        fm = 2'h1;
        host.burst(8'h01, 4, 0);
        chk(20'(flags), 20'h3f);
        put(20'h1c000, 12'h321, 1'b0);
        host.burst(8'h00, 11, 0);
        chk_got(pv, tv, dlt, 8'hee, 8'hee, 1'b1);
        frd = 1'b1;
        @(posedge clk_sys_i);
        #1;
        frd = 1'b0;
        @(posedge clk_sys_i);
        #1;
        chk(20'(flags), 20'h0);
        fm = 2'h0;
        op = pv;
        ot = tv;
        od = dlt;
        fork
            host.burst(8'h00, 11, 1);
            begin
                repeat (6) @(posedge clk_sys_i);
                put(20'h0beef, 12'hc08, 1'b0);
            end
        join
        chk_got(op, ot, od, 8'h00, 8'h00, 1'b0);
        host.burst(8'h00, 11, 0);
        chk_got(pv, tv, dlt, 8'h00, 8'h00, 1'b0);
        rst_chk();
        results();
    end
endmodule : ptv_out_regs_tb
